// ===== design/flash_host_pkg.sv
// Constants, types and timing of the parallel flash command host
package flash_host_pkg;
	// ******************************************************************
	// Register map and status fields
	// ******************************************************************
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_DATA   = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam int ST_BUSY    = 0;
	localparam int ST_TOGGLE  = 1;
	localparam int ST_FAIL    = 2;
	localparam int ST_BYPASS  = 3;
	localparam int ST_WINDOW  = 4;
	localparam int ST_REFUSED = 5;
	localparam int ST_RDY     = 6;
	localparam int ST_RDATA   = 8;
	localparam int ST_STARTED = 16;
	localparam int FLASH_AW   = 19;
	// ******************************************************************
	// Command bytes and addresses, byte-wide mode
	// ******************************************************************
	localparam logic [11:0] CMD_ADDR1  = 12'haaa;
	localparam logic [11:0] CMD_ADDR2  = 12'h555;
	localparam logic [7:0]  UNLOCK1    = 8'haa;
	localparam logic [7:0]  UNLOCK2    = 8'h55;
	localparam logic [7:0]  C_RESET    = 8'hf0;
	localparam logic [7:0]  C_AUTOSEL  = 8'h90;
	localparam logic [7:0]  C_PROGRAM  = 8'ha0;
	localparam logic [7:0]  C_BYPASS   = 8'h20;
	localparam logic [7:0]  C_BYP_EXIT = 8'h00;
	localparam logic [7:0]  C_ERASE    = 8'h80;
	localparam logic [7:0]  C_CHIP     = 8'h10;
	localparam logic [7:0]  C_BLOCK    = 8'h30;
	localparam logic [7:0]  C_SUSPEND  = 8'hb0;
	localparam logic [7:0]  C_RESUME   = 8'h30;
	// ******************************************************************
	// Timing
	// ******************************************************************
	localparam int CLK_NS   = 25;
	localparam int WP_NS    = 45;
	localparam int WPH_NS   = 30;
	localparam int ACC_NS   = 70;
	localparam int WIN_US   = 50;
	localparam int SYNC_CYC = 4;
	localparam int WP_CYC   = (WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WPH_CYC  = (WPH_NS + CLK_NS - 1) / CLK_NS;
	localparam int RD_CYC   = (ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
	localparam int WIN_CYC  = (WIN_US * 1000) / CLK_NS;
	// ******************************************************************
	// Types
	// ******************************************************************
	typedef enum logic [3:0] {
		OP_RESET1, OP_RESET3, OP_AUTOSEL, OP_PROGRAM, OP_BYPASS,
		OP_BYP_PROG, OP_BYP_EXIT, OP_CHIP, OP_BLOCK, OP_BLOCK_ADD,
		OP_SUSPEND, OP_RESUME, OP_READ, OP_POLL
	} op_t;
	typedef enum logic [2:0] {
		S_IDLE     = 3'b000,
		S_WR_SETUP = 3'b001,
		S_WR_PULSE = 3'b011,
		S_WR_HOLD  = 3'b010,
		S_WR_GAP   = 3'b110,
		S_RD_WAIT  = 3'b111,
		S_RD_DONE  = 3'b101
	} seq_state_t;
	typedef struct packed {
		logic                cyc;
		logic                stb;
		logic                we;
		logic [3:0]          sel;
		logic [7:0]          adr;
		logic [31:0]         dat;
	} wb_req_t;
	typedef struct packed {
		logic [FLASH_AW-1:0] addr;
		logic [7:0]          dqOut;
		logic                dqOeN;
		logic                ceN;
		logic                weN;
		logic                oeN;
	} flash_pins_t;
	typedef struct packed {
		logic [FLASH_AW-1:0] addr;
		logic [7:0]          data;
		logic                last;
	} step_t;
	typedef struct packed {
		seq_state_t          state;
		op_t                 op;
		logic [2:0]          step;
		logic [2:0]          cnt;
		logic [FLASH_AW-1:0] target;
		logic [7:0]          wdata;
		logic [7:0]          rdata;
		logic [7:0]          prevRd;
		flash_pins_t         pins;
		logic                toggled;
		logic                failSeen;
		logic                bypass;
		logic                refused;
		logic [11:0]         winCnt;
		logic [7:0]          dqS1;
		logic [7:0]          dqS2;
		logic [7:0]          dqS3;
		logic [7:0]          dqStable;
		logic [2:0]          rbSync;
		logic                rbStable;
		logic                ack;
		logic [31:0]         wbDat;
	} ctrl_state_t;
	localparam ctrl_state_t ST_RESET = '{
		state: S_IDLE, op: OP_READ,
		pins: '{addr: '0, dqOut: 8'h00, dqOeN: 1'b1, ceN: 1'b1,
			weN: 1'b1, oeN: 1'b1},
		rbSync: 3'h7, rbStable: 1'b1, default: '0};
endpackage

// ===== design/flash_cmd_host.sv
// Wishbone-driven host that issues flash command sequences and polls status
//
// Behaviour
// - Auto select is AA@AAA, 55@555, 90@AAA; short reset ends F0 anywhere.
// - Program is unlock pair, A0@AAA, then data at its target.
// - Unlock bypass entry is unlock pair then 20@AAA.
// - Bypass program is A0 anywhere, then data at the target.
// - Bypass exit is 90 then 00, both anywhere.
// - Chip erase: pair, 80@AAA, pair, 10@AAA; erasing starts after.
// - Block erase ends 30 inside the block; repeats add blocks.
// - Suspend is B0 anywhere; resume is 30 anywhere.
// - Fail flag set when a poll sees DQ6 toggle with DQ5 high; host must reset before anything else.
// - Each added block follows the previous within 50 us.
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_host
	import flash_host_pkg::*;
#(
	parameter int WIN_CYCLES = WIN_CYC
)
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Wishbone slave
	input  wire wb_req_t     wbReq,
	output logic [31:0]      wbDatO,
	output logic             wbAck,
	// Flash pins
	output flash_pins_t      flashPins,
	input  wire logic [7:0]  flashDqIn,
	input  wire logic        readyBusyIn
);
	initial begin
		if (WIN_CYCLES < 1 || WIN_CYCLES > 4095)
			$error("WIN_CYCLES out of range");
	end

	// ******************************************************************
	// Command sequence table
	// ******************************************************************
	function automatic step_t seqStep(input op_t op, input logic [2:0] idx,
		input logic [FLASH_AW-1:0] tgt, input logic [7:0] wd);
		step_t s;
		s.addr = {7'h00, CMD_ADDR1};
		s.data = UNLOCK1;
		s.last = 1'b0;
		if (idx == 3'd1 || idx == 3'd4)
		begin
			s.addr = {7'h00, CMD_ADDR2};
			s.data = UNLOCK2;
		end
		case (op)
			OP_RESET1:    s = '{addr: '0, data: C_RESET, last: 1'b1};
			OP_RESET3:
				if (idx == 3'd2)
					s = '{addr: '0, data: C_RESET, last: 1'b1};
			OP_AUTOSEL:
				if (idx == 3'd2)
				begin
					s.data = C_AUTOSEL;
					s.last = 1'b1;
				end
			OP_PROGRAM:
				if (idx == 3'd2)
					s.data = C_PROGRAM;
				else if (idx == 3'd3)
					s = '{addr: tgt, data: wd, last: 1'b1};
			OP_BYPASS:
				if (idx == 3'd2)
				begin
					s.data = C_BYPASS;
					s.last = 1'b1;
				end
			OP_BYP_PROG:
				if (idx == 3'd0)
					s = '{addr: '0, data: C_PROGRAM, last: 1'b0};
				else
					s = '{addr: tgt, data: wd, last: 1'b1};
			OP_BYP_EXIT:
				if (idx == 3'd0)
					s = '{addr: '0, data: C_AUTOSEL, last: 1'b0};
				else
					s = '{addr: '0, data: C_BYP_EXIT, last: 1'b1};
			OP_CHIP:
				if (idx == 3'd2)
					s.data = C_ERASE;
				else if (idx == 3'd5)
				begin
					s.data = C_CHIP;
					s.last = 1'b1;
				end
			OP_BLOCK:
				if (idx == 3'd2)
					s.data = C_ERASE;
				else if (idx == 3'd5)
					s = '{addr: tgt, data: C_BLOCK, last: 1'b1};
			OP_BLOCK_ADD: s = '{addr: tgt, data: C_BLOCK, last: 1'b1};
			OP_SUSPEND:   s = '{addr: '0, data: C_SUSPEND, last: 1'b1};
			OP_RESUME:    s = '{addr: '0, data: C_RESUME, last: 1'b1};
			default:      s.last = 1'b1;
		endcase
		return s;
	endfunction

	ctrl_state_t st_q;
	ctrl_state_t st_d;
	step_t       curStep;
	logic        busReq;
	logic        cmdWrite;
	logic        legal;
	logic        accept;
	logic        isReset;
	logic [7:0]  b;
	op_t         newOp;

	assign busReq   = wbReq.cyc && wbReq.stb && !st_q.ack;
	assign cmdWrite = busReq && wbReq.we && wbReq.adr == REG_CMD
		&& wbReq.sel[0];
	assign newOp    = op_t'(wbReq.dat[3:0]);
	assign isReset  = newOp == OP_RESET1 || newOp == OP_RESET3;
	assign curStep  = seqStep(st_q.op, st_q.step, st_q.target, st_q.wdata);
	assign legal    = wbReq.dat[3:0] <= 4'(OP_POLL)
		&& !(st_q.failSeen && !isReset)
		&& !(newOp == OP_BYP_PROG && !st_q.bypass)
		&& !(newOp == OP_BLOCK_ADD && st_q.winCnt == 12'h000);
	assign accept   = cmdWrite && st_q.state == S_IDLE && legal;

	// ******************************************************************
	// Next state
	// ******************************************************************
	always_comb
	begin
		b = 8'h00;
		st_d = st_q;
		// Pin inputs: three flops, change taken when last two agree
		st_d.dqS1 = flashDqIn;
		st_d.dqS2 = st_q.dqS1;
		st_d.dqS3 = st_q.dqS2;
		if (st_q.dqS2 == st_q.dqS3)
			st_d.dqStable = st_q.dqS3;
		st_d.rbSync = {st_q.rbSync[1:0], readyBusyIn};
		if (st_q.rbSync[1] == st_q.rbSync[2])
			st_d.rbStable = st_q.rbSync[2];
		if (st_q.winCnt != 12'h000)
			st_d.winCnt = st_q.winCnt - 12'h001;
		// Register bus
		st_d.ack = busReq;
		st_d.wbDat = 32'h0000_0000;
		if (busReq && !wbReq.we)
			case (wbReq.adr)
				REG_ADDR:   st_d.wbDat = 32'(st_q.target);
				REG_DATA:   st_d.wbDat = {24'h000000, st_q.wdata};
				REG_STATUS:
				begin
					st_d.wbDat[ST_BUSY]    = st_q.state != S_IDLE;
					st_d.wbDat[ST_TOGGLE]  = st_q.toggled;
					st_d.wbDat[ST_FAIL]    = st_q.failSeen;
					st_d.wbDat[ST_BYPASS]  = st_q.bypass;
					st_d.wbDat[ST_WINDOW]  = st_q.winCnt != 12'h000;
					st_d.wbDat[ST_REFUSED] = st_q.refused;
					st_d.wbDat[ST_RDY]     = st_q.rbStable;
					st_d.wbDat[ST_RDATA+:8] = st_q.rdata;
					st_d.wbDat[ST_STARTED] = st_q.rdata[3];
				end
				default:    st_d.wbDat = 32'h0000_0000;
			endcase
		if (busReq && wbReq.we && st_q.state == S_IDLE)
		begin
			if (wbReq.adr == REG_DATA && wbReq.sel[0])
				st_d.wdata = wbReq.dat[7:0];
			if (wbReq.adr == REG_ADDR)
				for (int i = 0; i < 3; i++)
					if (wbReq.sel[i])
						for (int j = 0; j < 8; j++)
							if (i * 8 + j < FLASH_AW)
								st_d.target[i*8+j] = wbReq.dat[i*8+j];
		end
		if (cmdWrite)
			st_d.refused = !accept;
		if (accept)
		begin
			st_d.op = newOp;
			st_d.step = 3'd0;
			st_d.toggled = 1'b0;
			if (newOp == OP_READ || newOp == OP_POLL)
			begin
				st_d.state = S_RD_WAIT;
				st_d.cnt = 3'(RD_CYC - 1);
				st_d.pins.addr = st_q.target;
				st_d.pins.ceN = 1'b0;
				st_d.pins.oeN = 1'b0;
			end
			else
				st_d.state = S_WR_SETUP;
		end
		// Pin sequencer
		case (st_q.state)
			S_IDLE: ;
			S_WR_SETUP:
			begin
				st_d.pins.addr = curStep.addr;
				st_d.pins.dqOut = curStep.data;
				st_d.pins.dqOeN = 1'b0;
				st_d.pins.ceN = 1'b0;
				st_d.pins.weN = 1'b0;
				st_d.cnt = 3'(WP_CYC - 1);
				st_d.state = S_WR_PULSE;
			end
			S_WR_PULSE:
				if (st_q.cnt == 3'd0)
				begin
					st_d.pins.weN = 1'b1;
					st_d.state = S_WR_HOLD;
				end
				else
					st_d.cnt = st_q.cnt - 3'd1;
			S_WR_HOLD:
			begin
				st_d.pins.ceN = 1'b1;
				st_d.pins.dqOeN = 1'b1;
				st_d.cnt = 3'(WPH_CYC - 1);
				st_d.state = S_WR_GAP;
			end
			S_WR_GAP:
				if (st_q.cnt != 3'd0)
					st_d.cnt = st_q.cnt - 3'd1;
				else if (!curStep.last)
				begin
					st_d.step = st_q.step + 3'd1;
					st_d.state = S_WR_SETUP;
				end
				else
				begin
					st_d.state = S_IDLE;
					if (st_q.op == OP_BLOCK || st_q.op == OP_BLOCK_ADD)
						st_d.winCnt = 12'(WIN_CYCLES);
					if (st_q.op == OP_SUSPEND || st_q.op == OP_CHIP)
						st_d.winCnt = 12'h000;
					if (st_q.op == OP_RESET1 || st_q.op == OP_RESET3)
						st_d.failSeen = 1'b0;
					if (st_q.op == OP_BYPASS)
						st_d.bypass = 1'b1;
					if (st_q.op == OP_BYP_EXIT)
						st_d.bypass = 1'b0;
				end
			S_RD_WAIT:
				if (st_q.cnt == 3'd0)
				begin
					st_d.rdata = st_q.dqStable;
					st_d.pins.ceN = 1'b1;
					st_d.pins.oeN = 1'b1;
					st_d.state = S_RD_DONE;
				end
				else
					st_d.cnt = st_q.cnt - 3'd1;
			S_RD_DONE:
				if (st_q.op == OP_POLL && st_q.step == 3'd0)
				begin
					st_d.prevRd = st_q.rdata;
					st_d.step = 3'd1;
					st_d.cnt = 3'(RD_CYC - 1);
					st_d.pins.ceN = 1'b0;
					st_d.pins.oeN = 1'b0;
					st_d.state = S_RD_WAIT;
				end
				else
				begin
					b = st_q.rdata ^ st_q.prevRd;
					st_d.toggled = st_q.op == OP_POLL && b[6];
					if (st_q.op == OP_POLL && b[6] && st_q.rdata[5])
						st_d.failSeen = 1'b1;
					st_d.state = S_IDLE;
				end
			default: st_d = ST_RESET;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			st_q <= ST_RESET;
		else
			st_q <= st_d;
	end

	assign wbDatO    = st_q.wbDat;
	assign wbAck     = st_q.ack;
	assign flashPins = st_q.pins;

	// ******************************************************************
	// Checks
	// ******************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic weFall;
	logic prefixed;
	// First cycle of the write pulse, counter still at its load value
	assign weFall   = st_q.state == S_WR_PULSE
		&& st_q.cnt == 3'(WP_CYC - 1);
	assign prefixed = st_q.op inside {OP_RESET3, OP_AUTOSEL, OP_PROGRAM,
		OP_BYPASS, OP_CHIP, OP_BLOCK};

	a_unlock_first: assert property (weFall && prefixed && st_q.step == 3'd0
		|-> st_q.pins.addr == 19'haaa && st_q.pins.dqOut == 8'haa)
		else $error("first unlock write wrong");
	a_unlock_second: assert property (weFall && prefixed
		&& st_q.step == 3'd1 |-> st_q.pins.addr == 19'h555
		&& st_q.pins.dqOut == 8'h55)
		else $error("second unlock write wrong");
	a_program_data: assert property (weFall && st_q.op == OP_PROGRAM
		&& st_q.step == 3'd3 |-> st_q.pins.addr == st_q.target
		&& st_q.pins.dqOut == st_q.wdata && $past(st_q.pins.dqOut, 1)
		== 8'ha0)
		else $error("program sequence wrong");
	a_bypass_enter: assert property (weFall && st_q.op == OP_BYPASS
		&& st_q.step == 3'd2 |-> st_q.pins.dqOut == 8'h20
		##6 st_q.bypass)
		else $error("bypass entry wrong");
	a_bypass_prog: assert property (weFall && st_q.op == OP_BYP_PROG
		&& st_q.step == 3'd0 |-> st_q.pins.dqOut == 8'ha0
		##8 st_q.pins.dqOut == st_q.wdata)
		else $error("bypass program wrong");
	a_bypass_exit: assert property (weFall && st_q.op == OP_BYP_EXIT
		&& st_q.step == 3'd0 |-> st_q.pins.dqOut == 8'h90
		##8 st_q.pins.dqOut == 8'h00 ##6 !st_q.bypass)
		else $error("bypass exit wrong");
	a_chip_last: assert property (weFall && st_q.op == OP_CHIP
		&& st_q.step == 3'd5 |-> st_q.pins.addr == 19'haaa
		&& st_q.pins.dqOut == 8'h10)
		else $error("chip erase last write wrong");
	a_block_last: assert property (weFall && (st_q.op == OP_BLOCK_ADD
		|| st_q.op == OP_BLOCK && st_q.step == 3'd5)
		|-> st_q.pins.addr == st_q.target && st_q.pins.dqOut == 8'h30
		##6 st_q.winCnt == 12'(WIN_CYCLES - 1))
		else $error("block select write wrong");
	a_suspend_one: assert property (weFall && st_q.op == OP_SUSPEND
		|-> st_q.pins.dqOut == 8'hb0 && st_q.step == 3'd0)
		else $error("suspend write wrong");
	a_fail_lock: assert property (cmdWrite && st_q.failSeen && !isReset
		|=> st_q.refused && st_q.state == S_IDLE)
		else $error("command taken while fail pending");
	a_window_open: assert property (accept && newOp == OP_BLOCK_ADD
		|-> st_q.winCnt != 12'h000)
		else $error("block added after window");
	a_reset_bypass: assert property (st_q.bypass && st_q.state == S_WR_GAP
		&& st_q.op == OP_RESET1 |=> st_q.bypass)
		else $error("reset left bypass mode");
	a_we_width: assert property ($fell(st_q.pins.weN)
		|-> !st_q.pins.weN [*2] ##1 st_q.pins.weN)
		else $error("write pulse width wrong");

	c_program: cover property (weFall && st_q.op == OP_PROGRAM
		&& st_q.step == 3'd3);
	c_chip: cover property (weFall && st_q.op == OP_CHIP && st_q.step == 3'd5);
	c_block_add: cover property (accept && newOp == OP_BLOCK_ADD);
	c_poll_toggle: cover property ($rose(st_q.toggled));
endmodule
`default_nettype wire

// ===== sim/flash_dev_model.sv
// Behavioural model of the parallel flash device behind the host
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model
	import flash_host_pkg::*;
#(
	parameter logic [7:0] MAKER_ID    = 8'h5c,
	parameter int         PROG_TICKS  = 200,
	parameter int         ERASE_TICKS = 400
)
(
	// Host side pins
	input  wire flash_pins_t flashPins,
	output logic [7:0]       flashDqIn,
	output logic             readyBusyIn
);
	logic [7:0]  mem [int];
	logic [26:0] wrLog [$];
	int          busyCnt = 0;
	int          step = 0;
	logic        prog = 1'b0;
	logic        byp = 1'b0;
	logic        fail = 1'b0;
	logic        susp = 1'b0;
	logic        autoSel = 1'b0;
	logic        erasing = 1'b0;
	logic        tog = 1'b0;
	logic        altTog = 1'b0;
	logic        pBit7 = 1'b0;
	wire         busy = busyCnt != 0;
	wire         stMode = busy | fail;

	function automatic logic [7:0] rd(input logic [FLASH_AW-1:0] ad);
		return mem.exists(ad) ? mem[ad] : 8'hff;
	endfunction

	// ****************************************************************
	// Command decoder
	// ****************************************************************
	task automatic devWrite(input logic [FLASH_AW-1:0] ad, input logic [7:0] d);
		logic [11:0] a;
		a = ad[11:0];
		wrLog.push_back({ad, d});
		if (busy)
		begin
			if (d == C_SUSPEND) susp = 1'b1;
			if (d == C_RESUME) susp = 1'b0;
		end
		else if (prog)
		begin
			pBit7 = ~d[7];
			fail = |(d & ~rd(ad));
			mem[ad] = rd(ad) & d;
			busyCnt = fail ? 0 : PROG_TICKS;
			erasing = 1'b0;
			prog = 1'b0;
			step = 0;
		end
		else if (byp && step == 0 && d == C_PROGRAM) prog = 1'b1;
		else if (byp && step == 0 && d == C_AUTOSEL) step = 9;
		else if (step == 9)
		begin
			byp = d != C_BYP_EXIT;
			step = 0;
		end
		else if (d == C_RESET)
		begin
			// Bypass mode survives a plain reset
			fail = 1'b0;
			autoSel = 1'b0;
			step = 0;
		end
		else if (fail) step = 0;
		else
		case (step)
			0, 3: step = (a == CMD_ADDR1 && d == UNLOCK1) ? step + 1 : 0;
			1, 4: step = (a == CMD_ADDR2 && d == UNLOCK2) ? step + 1 : 0;
			2:
			begin
				step = (a == CMD_ADDR1 && d == C_ERASE) ? 3 : 0;
				if (a == CMD_ADDR1)
				begin
					autoSel = d == C_AUTOSEL;
					prog = d == C_PROGRAM;
					byp = byp | (d == C_BYPASS);
				end
			end
			5:
			begin
				// Any block erase clears the whole array here
				if ((a == CMD_ADDR1 && d == C_CHIP) || d == C_BLOCK)
				begin
					busyCnt = ERASE_TICKS;
					erasing = 1'b1;
					mem.delete();
				end
				step = 0;
			end
			default: step = 0;
		endcase
	endtask

	// ****************************************************************
	// Pins
	// ****************************************************************
	initial flashDqIn = 8'h00;
	assign readyBusyIn = !(busy && !susp);
	always #100 if (busyCnt > 0 && !susp) busyCnt--;
	always @(posedge flashPins.weN) if (!flashPins.ceN) devWrite(flashPins.addr, flashPins.dqOut);
	always @(negedge flashPins.oeN)
		if (!flashPins.ceN)
		begin
			if (stMode && !susp) tog = ~tog;
			if (stMode && erasing) altTog = ~altTog;
			flashDqIn = autoSel ? MAKER_ID : !stMode ? rd(flashPins.addr)
				: erasing ? {susp, tog, fail, 2'b01, altTog, 2'b00}
				: {pBit7, tog, fail, 5'h00};
		end
	// Released bus shows no stale value
	always @(posedge flashPins.oeN) flashDqIn = ~flashDqIn;
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the flash command host
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import flash_host_pkg::*;
	localparam int         WIN = 20;
	localparam logic [7:0] ID  = 8'h5c; // arbitrary value
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	wb_req_t     wbReq = '0;
	logic [31:0] wbDatO;
	logic        wbAck;
	flash_pins_t flashPins;
	logic [7:0]  flashDqIn;
	logic        readyBusyIn;
	logic [31:0] st;
	int          fail_count = 0;
	int          checks_done = 0;

	always #12.5 core_clk = ~core_clk;

	flash_cmd_host #(.WIN_CYCLES(WIN)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
		.wbReq(wbReq), .wbDatO(wbDatO), .wbAck(wbAck), .flashPins(flashPins),
		.flashDqIn(flashDqIn), .readyBusyIn(readyBusyIn));
	flash_dev_model #(.MAKER_ID(ID)) i_flash (.flashPins(flashPins),
		.flashDqIn(flashDqIn), .readyBusyIn(readyBusyIn));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
		// Look at the settled ack mid-cycle; release at the next edge
		do
		begin
			@(negedge core_clk);
			n++;
		end
		while (wbAck !== 1'b1 && n < 50);
		if (wbAck !== 1'b1) chk("ack", 1'b1, wbAck);
		st = wbDatO;
		@(posedge core_clk);
		wbReq <= '0;
		@(posedge core_clk);
	endtask
	// Issue one operation and wait until the host is idle again
	task automatic cmd(input logic [3:0] op, input logic [18:0] ad, input logic [7:0] d);
		int n;
		n = 0;
		wbXfer(1'b1, REG_ADDR, {13'h0, ad});
		wbXfer(1'b1, REG_DATA, {24'h0, d});
		wbXfer(1'b1, REG_CMD, {28'h0, op});
		do
		begin
			wbXfer(1'b0, REG_STATUS, '0);
			n++;
		end
		while (st[ST_BUSY] !== 1'b0 && n < 100);
	endtask
	task automatic settle(input logic [18:0] ad);
		int n;
		n = 0;
		do
		begin
			cmd(4'd13, ad, 8'h00);
			n++;
		end
		while (st[ST_TOGGLE] !== 1'b0 && n < 400);
	endtask
	// Address 12'hfff stands for a step whose address is free
	task automatic chkWr(input int back, input logic [11:0] a, input logic [7:0] d);
		logic [26:0] e;
		e = i_flash.wrLog[i_flash.wrLog.size() - back];
		if (a != 12'hfff) chk("write addr", {20'h0, a}, {20'h0, e[19:8]});
		chk("write data", {24'h0, d}, {24'h0, e[7:0]});
	endtask
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		chk("pins idle", 4'hf, {flashPins.ceN, flashPins.weN, flashPins.oeN, flashPins.dqOeN});
		wbXfer(1'b0, REG_STATUS, '0);
		chk("status after reset", 32'h40, st);
		wbXfer(1'b1, 8'h10, 32'hffff_ffff);
		wbXfer(1'b0, 8'h10, '0);
		chk("unmapped read", 32'h0, st);
	endtask
	task automatic t_program();
		cmd(4'd3, 19'h12345, 8'h5a);
		chkWr(4, CMD_ADDR1, UNLOCK1);
		chkWr(3, CMD_ADDR2, UNLOCK2);
		chkWr(2, CMD_ADDR1, C_PROGRAM);
		chkWr(1, 12'h345, 8'h5a);
		cmd(4'd13, 19'h12345, 8'h00);
		chk("busy poll", 2'b11, {st[15], st[ST_TOGGLE]});
		settle(19'h12345);
		chk("programmed", 8'h5a, st[15:8]);
	endtask
	task automatic t_fail();
		cmd(4'd3, 19'h12345, 8'hff);
		cmd(4'd13, 19'h12345, 8'h00);
		chk("fail pending", 1'b1, st[ST_FAIL]);
		cmd(4'd3, 19'h12345, 8'h00);
		chk("refused in fail", 1'b1, st[ST_REFUSED]);
		cmd(4'd1, 19'h0, 8'h00);
		chk("fail cleared", 2'b00, {st[ST_FAIL], st[ST_REFUSED]});
		chkWr(2, CMD_ADDR2, UNLOCK2);
		chkWr(1, 12'hfff, C_RESET);
		cmd(4'd12, 19'h12345, 8'h00);
		chk("bit kept low", 8'h5a, st[15:8]);
	endtask
	task automatic t_autosel();
		cmd(4'd2, 19'h0, 8'h00);
		chkWr(1, CMD_ADDR1, C_AUTOSEL);
		cmd(4'd12, 19'h0, 8'h00);
		chk("maker code", ID, st[15:8]);
		cmd(4'd0, 19'h0, 8'h00);
		chkWr(1, 12'hfff, C_RESET);
	endtask
	task automatic t_bypass();
		cmd(4'd5, 19'h100, 8'h3c);
		chk("bypass prog refused", 1'b1, st[ST_REFUSED]);
		cmd(4'd4, 19'h0, 8'h00);
		chkWr(1, CMD_ADDR1, C_BYPASS);
		cmd(4'd0, 19'h0, 8'h00);
		chk("bypass kept", 1'b1, st[ST_BYPASS]);
		cmd(4'd5, 19'h100, 8'h3c);
		chkWr(2, 12'hfff, C_PROGRAM);
		chkWr(1, 12'h100, 8'h3c);
		settle(19'h100);
		chk("bypass programmed", 8'h3c, st[15:8]);
		cmd(4'd6, 19'h0, 8'h00);
		chkWr(2, 12'hfff, C_AUTOSEL);
		chkWr(1, 12'hfff, C_BYP_EXIT);
		chk("bypass left", 1'b0, st[ST_BYPASS]);
	endtask
	task automatic t_chip();
		cmd(4'd7, 19'h0, 8'h00);
		chkWr(4, CMD_ADDR1, C_ERASE);
		chkWr(1, CMD_ADDR1, C_CHIP);
		cmd(4'd13, 19'h0, 8'h00);
		chk("chip erase poll", 3'b011, {st[15], st[ST_STARTED], st[ST_TOGGLE]});
		chk("busy pin", 1'b0, st[ST_RDY]);
		settle(19'h12345);
		chk("erased", 8'hff, st[15:8]);
	endtask
	task automatic t_block();
		cmd(4'd8, 19'h20abc, 8'h00);
		chkWr(1, 12'habc, C_BLOCK);
		chk("window open", 1'b1, st[ST_WINDOW]);
		cmd(4'd9, 19'h30555, 8'h00);
		chkWr(1, 12'h555, C_BLOCK);
		repeat (WIN + 4) @(posedge core_clk);
		cmd(4'd9, 19'h30555, 8'h00);
		chk("late add refused", 2'b10, {st[ST_REFUSED], st[ST_WINDOW]});
		cmd(4'd10, 19'h0, 8'h00);
		chkWr(1, 12'hfff, C_SUSPEND);
		cmd(4'd13, 19'h20abc, 8'h00);
		chk("suspended", 3'b101, {st[15], st[ST_TOGGLE], st[ST_RDY]});
		cmd(4'd11, 19'h0, 8'h00);
		chkWr(1, 12'hfff, C_RESUME);
		settle(19'h20abc);
	endtask

	initial
	begin
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_reset();
		t_program();
		t_fail();
		t_autosel();
		t_bypass();
		t_chip();
		t_block();
		give_verdict();
	end
	initial
	begin
		#1000000;
		fail_count++;
		give_verdict();
	end
endmodule
`default_nettype wire
